// ### hdl/sresc_pkg.sv
// shared constants and carriers for the slave response and eeprom control block
package sresc_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h50;
  localparam int DATA_W = 32;
  // bit positions inside the control register
  localparam int BIT_RD_NO_FLUSH = 16;
  localparam int BIT_RD_NO_WRITE = 17;
  localparam int BIT_WR_RELEASE = 18;
  localparam int BIT_RETRY_LO = 19;
  localparam int RETRY_W = 4;
  localparam int BIT_LOCK_EN = 23;
  localparam int BIT_EE_CLK = 24;
  localparam int BIT_EE_CS = 25;
  localparam int BIT_EE_WDATA = 26;
  localparam int BIT_EE_RDATA = 27;
  localparam int BIT_EE_VALID = 28;
  localparam int BIT_RELOAD = 29;
  localparam int BIT_SW_RESET = 30;
  localparam int BIT_REVISION = 31;
  // byte lanes that hold the upper half
  localparam int LANE_LOW_FIELDS = 2;
  localparam int LANE_EE_FIELDS = 3;
  // retry delay field counts in units of this many clocks
  localparam int RETRY_MULT = 8;
  localparam int TIMER_W = 7;
  localparam int SYNC_W = 2;
  localparam logic [TIMER_W-1:0] TIMER_MAX = 7'h7F;

  typedef struct packed {
    logic rd_no_flush;
    logic rd_no_write;
    logic wr_release;
    logic [RETRY_W-1:0] retry_dly;
    logic lock_en;
    logic ee_clk;
    logic ee_cs;
    logic ee_wdata;
    logic ee_valid;
    logic reload;
    logic sw_reset;
  } sresc_ctrl_type;

  localparam sresc_ctrl_type CTRL_RESET = '0;

  typedef struct packed {
    sresc_ctrl_type ctrl;
    logic [SYNC_W-1:0] ee_sync;
    logic [TIMER_W-1:0] timer;
    logic retry;
    logic reload_pulse;
    logic [DATA_W-1:0] rdata;
  } sresc_state_type;

  // register access request from the pci target
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [DATA_W-1:0] wdata;
  } sresc_req_type;

  // direct slave cycle status from the target datapath
  typedef struct packed {
    logic active;
    logic is_write;
    logic read_pending;
    logic wr_fifo_full;
    logic rd_data_ready;
    logic rd_complete;
    logic delayed_read_mode;
  } sresc_slave_type;

  // response controls back to the target datapath
  typedef struct packed {
    logic rd_fifo_flush;
    logic write_retry;
    logic write_disconnect;
    logic write_trdy_hold;
    logic read_disconnect;
    logic read_prefetch;
    logic read_trdy_hold;
    logic lock_enable;
  } sresc_resp_type;
endpackage : sresc_pkg

// ### hdl/sresc_ctrl.sv
// upper half of the target control register: slave response, eeprom bit-bang, resets
`timescale 1ns/1ns
// What this block does
// - read-ahead bit set keeps read fifo after a read completes, else flush
// - read-pending write-block bit set retries every write while a read pends
// - write release bit set disconnects the write when write fifo fills
// - write release bit clear holds trdy off until write fifo has room
// - retry issued after retry delay field times eight clocks of a slave cycle
// - delay counts for reads only without delayed read, writes only without block
// - lock enable bit set honours locked sequences, clear refuses them
// - eeprom clock output follows its control bit; software toggles edges
// - eeprom chip select output follows its control bit
// - eeprom serial data output follows the write data bit
// - read data bit shows eeprom serial output; writes to it do nothing
// - read-only eeprom valid bit shows a valid eeprom was found
// - writing one over a zero reload bit starts a configuration reload
// - software reset bit holds logic reset, asserts local reset, floats local bus
// - software reset stays until the host writes the bit back to zero
// - software reset leaves configuration register contents unchanged
// - delayed read mode disconnects and prefetches, else stalls trdy until data
module sresc_ctrl #(
  // arbitrary value, not tied to any part
  parameter logic REVISION = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register access
  input wire sresc_pkg::sresc_req_type req,
  output logic [sresc_pkg::DATA_W-1:0] rdata,
  // slave cycle status and response
  input wire sresc_pkg::sresc_slave_type slave,
  output sresc_pkg::sresc_resp_type resp,
  output logic retry_issue,
  // eeprom pins and loader
  output logic eeprom_serial_clock_out,
  output logic eeprom_chip_select_out,
  output logic eeprom_serial_data_out,
  input wire logic eeprom_serial_data_in,
  input wire logic eeprom_valid_set,
  input wire logic eeprom_valid_clr,
  output logic reload_start,
  // local bus reset
  output logic local_bus_reset_n,
  output logic local_bus_float
);
  sresc_pkg::sresc_state_type st_q;
  sresc_pkg::sresc_state_type st_d;
  logic wr_hit;
  logic rd_hit;
  logic lane_lo;
  logic lane_ee;
  logic retry_applies;
  logic [sresc_pkg::TIMER_W-1:0] retry_clocks;
  logic run;

  function automatic logic [sresc_pkg::DATA_W-1:0] pack_rdata(
    input sresc_pkg::sresc_ctrl_type c,
    input logic ee_in,
    input logic rev
  );
    logic [sresc_pkg::DATA_W-1:0] v;
    v = '0;
    v[sresc_pkg::BIT_RD_NO_FLUSH] = c.rd_no_flush;
    v[sresc_pkg::BIT_RD_NO_WRITE] = c.rd_no_write;
    v[sresc_pkg::BIT_WR_RELEASE] = c.wr_release;
    v[sresc_pkg::BIT_RETRY_LO +: sresc_pkg::RETRY_W] = c.retry_dly;
    v[sresc_pkg::BIT_LOCK_EN] = c.lock_en;
    v[sresc_pkg::BIT_EE_CLK] = c.ee_clk;
    v[sresc_pkg::BIT_EE_CS] = c.ee_cs;
    v[sresc_pkg::BIT_EE_WDATA] = c.ee_wdata;
    v[sresc_pkg::BIT_EE_RDATA] = ee_in;
    v[sresc_pkg::BIT_EE_VALID] = c.ee_valid;
    v[sresc_pkg::BIT_RELOAD] = c.reload;
    v[sresc_pkg::BIT_SW_RESET] = c.sw_reset;
    v[sresc_pkg::BIT_REVISION] = rev;
    return v;
  endfunction : pack_rdata

  assign wr_hit = req.wr && (req.addr == sresc_pkg::CTRL_OFFSET);
  assign rd_hit = req.rd && (req.addr == sresc_pkg::CTRL_OFFSET);
  assign lane_lo = wr_hit && req.be[sresc_pkg::LANE_LOW_FIELDS];
  assign lane_ee = wr_hit && req.be[sresc_pkg::LANE_EE_FIELDS];
  // operating logic stops while software reset is held
  assign run = !st_q.ctrl.sw_reset;
  assign retry_clocks = sresc_pkg::TIMER_W'(st_q.ctrl.retry_dly * sresc_pkg::RETRY_MULT);
  // field value zero is read as no timeout
  assign retry_applies = slave.is_write ? !st_q.ctrl.rd_no_write
                                        : !slave.delayed_read_mode;

  always_comb begin
    st_d = st_q;
    st_d.reload_pulse = 1'b0;
    st_d.retry = 1'b0;
    // first stage feeds only the second
    st_d.ee_sync = {st_q.ee_sync[0], eeprom_serial_data_in};
    if (lane_lo) begin
      st_d.ctrl.rd_no_flush = req.wdata[sresc_pkg::BIT_RD_NO_FLUSH];
      st_d.ctrl.rd_no_write = req.wdata[sresc_pkg::BIT_RD_NO_WRITE];
      st_d.ctrl.wr_release = req.wdata[sresc_pkg::BIT_WR_RELEASE];
      st_d.ctrl.retry_dly[0] = req.wdata[sresc_pkg::BIT_RETRY_LO];
    end
    if (lane_ee) begin
      st_d.ctrl.retry_dly[sresc_pkg::RETRY_W-1:1] =
        req.wdata[sresc_pkg::BIT_LOCK_EN-1:sresc_pkg::BIT_RETRY_LO+1];
      st_d.ctrl.lock_en = req.wdata[sresc_pkg::BIT_LOCK_EN];
      st_d.ctrl.ee_clk = req.wdata[sresc_pkg::BIT_EE_CLK];
      st_d.ctrl.ee_cs = req.wdata[sresc_pkg::BIT_EE_CS];
      st_d.ctrl.ee_wdata = req.wdata[sresc_pkg::BIT_EE_WDATA];
      st_d.ctrl.reload = req.wdata[sresc_pkg::BIT_RELOAD];
      // only the host clears it, never the block itself
      st_d.ctrl.sw_reset = req.wdata[sresc_pkg::BIT_SW_RESET];
      st_d.reload_pulse = req.wdata[sresc_pkg::BIT_RELOAD] && !st_q.ctrl.reload;
    end
    // valid flag is hardware owned; a set beats a clear
    if (eeprom_valid_set) begin
      st_d.ctrl.ee_valid = 1'b1;
    end else if (eeprom_valid_clr) begin
      st_d.ctrl.ee_valid = 1'b0;
    end
    if (rd_hit) begin
      st_d.rdata = pack_rdata(st_q.ctrl, st_q.ee_sync[1], REVISION);
    end
    // timer is operating logic: cleared by software reset, registers are not
    if (!run || !slave.active) begin
      st_d.timer = '0;
    end else begin
      if (st_q.timer != sresc_pkg::TIMER_MAX) begin
        st_d.timer = st_q.timer + 1'b1;
      end
      st_d.retry = retry_applies && (retry_clocks != '0)
                   && (st_q.timer == retry_clocks - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q.ctrl <= sresc_pkg::CTRL_RESET;
      st_q.ee_sync <= '0;
      st_q.timer <= '0;
      st_q.retry <= 1'b0;
      st_q.reload_pulse <= 1'b0;
      st_q.rdata <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // responses are handshake terms, gated off during software reset
  always_comb begin
    resp = '0;
    if (run) begin
      resp.rd_fifo_flush = slave.rd_complete && !st_q.ctrl.rd_no_flush;
      resp.write_retry = slave.active && slave.is_write
                         && st_q.ctrl.rd_no_write && slave.read_pending;
      resp.write_disconnect = slave.active && slave.is_write && !resp.write_retry
                              && slave.wr_fifo_full && st_q.ctrl.wr_release;
      resp.write_trdy_hold = slave.active && slave.is_write && !resp.write_retry
                             && slave.wr_fifo_full && !st_q.ctrl.wr_release;
      resp.read_disconnect = slave.active && !slave.is_write
                             && slave.delayed_read_mode && !slave.rd_data_ready;
      resp.read_prefetch = resp.read_disconnect;
      resp.read_trdy_hold = slave.active && !slave.is_write
                            && !slave.delayed_read_mode && !slave.rd_data_ready;
      resp.lock_enable = st_q.ctrl.lock_en;
    end
  end

  assign rdata = st_q.rdata;
  assign retry_issue = st_q.retry;
  assign reload_start = st_q.reload_pulse;
  assign eeprom_serial_clock_out = st_q.ctrl.ee_clk;
  assign eeprom_chip_select_out = st_q.ctrl.ee_cs;
  assign eeprom_serial_data_out = st_q.ctrl.ee_wdata;
  // pci reset does not appear as local reset: ctrl clears to zero at once, so local_bus_reset_n stays high
  assign local_bus_reset_n = !st_q.ctrl.sw_reset;
  assign local_bus_float = st_q.ctrl.sw_reset;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // read fifo handling
  a_rd_flush_mode: assert property (
    slave.rd_complete && run |-> resp.rd_fifo_flush == !st_q.ctrl.rd_no_flush)
    else $error("flush mode wrong");

  // write response while a read pends
  a_write_block_retry: assert property (
    slave.active && slave.is_write && slave.read_pending && st_q.ctrl.rd_no_write && run
    |-> resp.write_retry && !resp.write_trdy_hold)
    else $error("write not retried while read pending");

  a_write_free_pend: assert property (
    run && slave.active && slave.is_write && !st_q.ctrl.rd_no_write |-> !resp.write_retry)
    else $error("write retried with block off");

  // full write fifo: release or hold
  a_full_release: assert property (
    resp.write_disconnect |-> slave.wr_fifo_full && st_q.ctrl.wr_release)
    else $error("bad disconnect");

  a_full_release_set: assert property (
    run && slave.active && slave.is_write && slave.wr_fifo_full && st_q.ctrl.wr_release
    && !resp.write_retry |-> resp.write_disconnect)
    else $error("write not released on full fifo");

  a_full_hold: assert property (
    run && slave.active && slave.is_write && slave.wr_fifo_full
    && !st_q.ctrl.wr_release && !resp.write_retry |-> resp.write_trdy_hold)
    else $error("trdy not held on full fifo");

  a_hold_needs_full: assert property (
    resp.write_trdy_hold |-> slave.wr_fifo_full && !st_q.ctrl.wr_release)
    else $error("trdy held without full fifo");

  // retry timeout
  a_retry_delay_count: assert property (
    retry_issue |-> $past(st_q.timer) == retry_clocks - 1'b1 && $past(slave.active)
    && $past(retry_applies))
    else $error("retry at wrong count");

  a_retry_pulse_once: assert property (
    retry_issue |=> !retry_issue)
    else $error("retry pulse too long");

  a_retry_zero_off: assert property (
    retry_issue |-> $past(retry_clocks) != '0)
    else $error("retry with zero delay field");

  // lock support
  a_lock_follows: assert property (
    run |-> resp.lock_enable == st_q.ctrl.lock_en)
    else $error("lock enable not following bit");

  // eeprom pins
  a_ee_pins_follow: assert property (
    lane_ee |=> eeprom_serial_clock_out == $past(req.wdata[sresc_pkg::BIT_EE_CLK])
    && eeprom_chip_select_out == $past(req.wdata[sresc_pkg::BIT_EE_CS]))
    else $error("eeprom pins not following write");

  a_ee_cs_steady: assert property (
    !lane_ee |=> $stable(eeprom_chip_select_out))
    else $error("eeprom select moved without write");

  a_ee_data_follow: assert property (
    lane_ee |=> eeprom_serial_data_out == $past(req.wdata[sresc_pkg::BIT_EE_WDATA]))
    else $error("eeprom data not following write");

  // read path
  a_ee_read_sync: assert property (
    rd_hit |=> rdata[sresc_pkg::BIT_EE_RDATA] == $past(eeprom_serial_data_in, 3))
    else $error("eeprom data not synchronised");

  a_rdata_hold: assert property (
    !rd_hit |=> $stable(rdata))
    else $error("read data moved without read");

  a_revision_fixed: assert property (
    rd_hit |=> rdata[sresc_pkg::BIT_REVISION] == REVISION)
    else $error("revision bit wrong");

  // valid flag owned by the loader
  a_valid_set: assert property (
    eeprom_valid_set |=> st_q.ctrl.ee_valid)
    else $error("valid flag not set");

  a_valid_steady: assert property (
    !eeprom_valid_set && !eeprom_valid_clr |=> $stable(st_q.ctrl.ee_valid))
    else $error("valid flag moved by software");

  // configuration reload
  a_reload_edge: assert property (
    reload_start |-> $past(lane_ee) && !$past(st_q.ctrl.reload))
    else $error("spurious reload");

  a_reload_starts: assert property (
    lane_ee && req.wdata[sresc_pkg::BIT_RELOAD] && !st_q.ctrl.reload |=> reload_start)
    else $error("reload not started");

  // software reset
  a_sw_reset_gates: assert property (
    st_q.ctrl.sw_reset |-> resp == '0 && st_d.timer == '0)
    else $error("logic active in software reset");

  a_sw_reset_held: assert property (
    st_q.ctrl.sw_reset && !lane_ee |=> st_q.ctrl.sw_reset && !local_bus_reset_n
    && local_bus_float)
    else $error("software reset dropped");

  a_sw_reset_keeps: assert property (
    st_q.ctrl.sw_reset && !lane_ee && !lane_lo |=> $stable(st_q.ctrl.retry_dly)
    && $stable(st_q.ctrl.lock_en))
    else $error("configuration lost in software reset");

  // read responses
  a_read_prefetch: assert property (
    run && slave.active && !slave.is_write && slave.delayed_read_mode && !slave.rd_data_ready
    |-> resp.read_disconnect && resp.read_prefetch && !resp.read_trdy_hold)
    else $error("delayed read not disconnected");

  a_read_stall: assert property (
    run && slave.active && !slave.is_write && !slave.delayed_read_mode
    && !slave.rd_data_ready |-> resp.read_trdy_hold && !resp.read_disconnect)
    else $error("read not stalled");

  // main scenarios
  c_retry_seen: cover property (retry_issue);
  c_reload_seen: cover property (reload_start);
  c_sw_reset_cycle: cover property ($rose(st_q.ctrl.sw_reset) ##[1:20] $fell(st_q.ctrl.sw_reset));
  c_write_hold_seen: cover property (resp.write_trdy_hold);
  c_read_prefetch_seen: cover property (resp.read_prefetch);
endmodule : sresc_ctrl

// ### verif/sresc_ee_model.sv
// behavioural serial eeprom: captures a bit on its clock, answers the inverse
`timescale 1ns/1ns
module sresc_ee_model (
  // eeprom pins
  input wire logic sk,
  input wire logic cs,
  input wire logic di,
  output logic dout
);
  logic last_q = 1'b0;
  always @(posedge sk) begin
    if (cs) begin
      last_q <= di;
    end
  end
  // a deselected part releases the line to its pull-up
  assign dout = cs ? ~last_q : 1'b1;
endmodule : sresc_ee_model

// ### verif/slave_response_eeprom_control_tb.sv
// self-checking bench for the slave response and eeprom control register
`timescale 1ns/1ns
module slave_response_eeprom_control_tb;
  logic clk;
  logic resetn;
  sresc_pkg::sresc_req_type req;
  sresc_pkg::sresc_slave_type sl;
  sresc_pkg::sresc_resp_type resp;
  logic [31:0] rdata;
  logic retry_issue, sk, cs, di, dout, v_set, v_clr, reload_start, lb_rst_n, lb_float, b;
  int n_fail = 0;
  int checks = 0;

  sresc_ctrl i_dut (
    .clk(clk),
    .resetn(resetn),
    .req(req),
    .rdata(rdata),
    .slave(sl),
    .resp(resp),
    .retry_issue(retry_issue),
    .eeprom_serial_clock_out(sk),
    .eeprom_chip_select_out(cs),
    .eeprom_serial_data_out(di),
    .eeprom_serial_data_in(dout),
    .eeprom_valid_set(v_set),
    .eeprom_valid_clr(v_clr),
    .reload_start(reload_start),
    .local_bus_reset_n(lb_rst_n),
    .local_bus_float(lb_float)
  );

  sresc_ee_model i_ee (.sk(sk), .cs(cs), .di(di), .dout(dout));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic close_out;
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    wait_clk(1);
    req = '{wr:1'b1, rd:1'b0, addr:a, be:be, wdata:d};
    wait_clk(1);
    req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wait_clk(1);
    req = '{wr:1'b0, rd:1'b1, addr:a, be:4'hF, wdata:32'h0000_0000};
    wait_clk(1);
    req.rd = 1'b0;
    chk(rdata, exp);
  endtask : rd

  // slave vector: active, write, pending, full, ready, complete, delayed
  task automatic timer(input logic [31:0] cfg, input logic [6:0] s, input int hit);
    wr(8'h50, 4'hC, cfg);
    sl = s;
    for (int i = 1; i <= 30; i++) begin
      wait_clk(1);
      chk({31'h0, retry_issue}, {31'h0, i == hit});
    end
    sl = '0;
    wait_clk(1);
  endtask : timer

  // a hang ends the run as a failure
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial begin
    resetn = 1'b0;
    req = '0;
    sl = '0;
    v_set = 1'b0;
    v_clr = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    wait_clk(3);
    rd(8'h50, 32'h0800_0000);
    chk({sk, cs, di, lb_rst_n, lb_float}, 5'h02);
    wr(8'h50, 4'hC, 32'h98FF_0000);
    wr(8'h54, 4'hC, 32'h0000_0000);
    rd(8'h50, 32'h08FF_0000);
    sl = 7'h7A;
    wait_clk(1);
    chk(resp, 8'h41);
    sl = '0;
    resetn = 1'b0;
    wait_clk(2);
    resetn = 1'b1;
    wait_clk(3);
    rd(8'h50, 32'h0800_0000);
    sl = 7'h7A;
    wait_clk(1);
    chk(resp, 8'h90);
    wr(8'h50, 4'hC, 32'h0004_0000);
    chk(resp, 8'hA0);
    sl = 7'h41;
    wait_clk(1);
    chk(resp, 8'h0C);
    sl = 7'h40;
    wait_clk(1);
    chk(resp, 8'h02);
    sl = '0;
    timer(32'h0018_0000, 7'h60, 24);
    timer(32'h001A_0000, 7'h60, 0);
    timer(32'h0018_0000, 7'h41, 0);
    timer(32'h0018_0000, 7'h40, 24);
    wr(8'h50, 4'hC, 32'h2000_0000);
    chk(reload_start, 1);
    wait_clk(1);
    chk(reload_start, 0);
    wr(8'h50, 4'hC, 32'h2000_0000);
    chk(reload_start, 0);
    wr(8'h50, 4'hC, 32'h40FF_0000);
    chk({lb_rst_n, lb_float}, 2'h1);
    sl = 7'h7A;
    wait_clk(5);
    chk(resp, 8'h00);
    chk({lb_rst_n, lb_float}, 2'h1);
    sl = '0;
    rd(8'h50, 32'h48FF_0000);
    wr(8'h50, 4'hC, 32'h0000_0000);
    chk({lb_rst_n, lb_float}, 2'h2);
    v_set = 1'b1;
    wait_clk(1);
    v_set = 1'b0;
    rd(8'h50, 32'h1800_0000);
    v_clr = 1'b1;
    wait_clk(1);
    v_clr = 1'b0;
    rd(8'h50, 32'h0800_0000);
    for (int k = 0; k < 4; k++) begin
      b = k[0];
      wr(8'h50, 4'hC, {5'h00, b, 2'h2, 24'h00_0000});
      wr(8'h50, 4'hC, {5'h00, b, 2'h3, 24'h00_0000});
      chk({sk, cs, di}, {2'h3, b});
      wait_clk(3);
      rd(8'h50, {4'h0, ~b, b, 2'h3, 24'h00_0000});
    end
    close_out();
  end
endmodule : slave_response_eeprom_control_tb
